// >>> sac_regs.svh
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
// ==========================================
// Parameter numbers
`define SAC_P_PD_RAMP 8'h1f
`define SAC_P_LS_WIDTH 8'h20
`define SAC_P_LS_STALL 8'h21
`define SAC_P_REL_ORIGIN 8'h7f
`define SAC_P_USTEP_RES 8'h8c
`define SAC_P_INTERP 8'ha0
`define SAC_P_DBL_STEP 8'ha1
`define SAC_P_BLANK 8'ha2
`define SAC_P_CHOP_MODE 8'ha3
`define SAC_P_FD_CMP_OFF 8'ha4
`define SAC_P_HEND_FD 8'ha5
`define SAC_P_HSTART_SO 8'ha6
`define SAC_P_OFF_TIME 8'ha7
`define SAC_P_CUR_FLOOR 8'ha8
`define SAC_P_CUR_DOWN 8'ha9
// ==========================================
// Reset values
`define SAC_RST_BLANK 2'h2
`define SAC_RST_OFF_TIME 4'h3
`define SAC_RST_USTEP_RES 4'h8
// ==========================================
// Field limits and timing
`define SAC_RES_MAX 4'h8
`define SAC_HSTART_MAX 4'h8
`define SAC_INTERP_RES 4'h4
`define SAC_OFF_BASE 9'h00c
`define SAC_OFF_MIN 9'h040
`define SAC_CLK_MHZ 50
`define SAC_PD_UNIT_US 163840
`define SAC_PD_UNIT_CYC (`SAC_PD_UNIT_US * `SAC_CLK_MHZ)
`endif

// >>> sac_pkg.sv
`default_nettype none
package sac_pkg;
  typedef enum logic {SAC_CHOP_HYST, SAC_CHOP_CONST} sac_chop_t;
  typedef enum logic [1:0] {SAC_PD_IDLE, SAC_PD_RAMP, SAC_PD_DONE} sac_pd_st_t;
endpackage
`default_nettype wire

// >>> sac_axis_cfg.sv
`include "sac_regs.svh"
`default_nettype none
module sac_axis_cfg #(
  parameter int PD_UNIT_CYC = `SAC_PD_UNIT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Parameter command port
  input wire logic cmd_valid_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_num_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic rsp_valid_o,
  output logic rsp_err_o,
  output logic [31:0] rsp_rdata_o,
  // Motion status and power-down ramp
  input wire logic motor_stopped_i,
  input wire logic settle_done_i,
  output logic pd_ramp_active_o,
  output logic [3:0] pd_level_o,
  // Load-adaptive step mode
  input wire logic [22:0] speed_i,
  input wire logic [22:0] min_speed_i,
  output logic load_step_active_o,
  output logic [9:0] load_step_width_o,
  output logic [7:0] load_step_stall_o,
  // Relative move
  input wire logic relative_move_command_i,
  input wire logic [31:0] rel_dist_i,
  input wire logic [31:0] target_pos_i,
  input wire logic [31:0] actual_pos_i,
  output logic rel_dest_valid_o,
  output logic [31:0] rel_dest_o,
  // Step and direction pins
  input wire logic step_pin_i,
  input wire logic dir_pin_i,
  output logic ustep_pulse_o,
  output logic ustep_dir_o,
  output logic [8:0] ustep_amount_o,
  output logic [3:0] ustep_log2_o,
  // Chopper settings
  output logic [1:0] blank_time_o,
  output logic chop_const_off_o,
  output logic fd_cmp_off_o,
  output logic [3:0] hyst_end_o,
  output logic [3:0] fast_decay_o,
  output logic [3:0] hyst_start_o,
  output logic [3:0] sine_offset_o,
  output logic [8:0] off_cycles_o,
  output logic freewheel_o,
  // Adaptive current
  input wire logic [4:0] cs_max_i,
  input wire logic load_high_i,
  output logic [4:0] cur_min_o,
  output logic cur_dec_o
);
  if (PD_UNIT_CYC < 1) $error("PD_UNIT_CYC must be at least one");

  // ==========================================
  // Decoding helpers
  function automatic logic [3:0] res_log2(input logic [3:0] code);
    res_log2 = code;
  endfunction
  function automatic logic [5:0] down_group(input logic [1:0] code);
    case (code)
      2'h0: down_group = 6'h20;
      2'h1: down_group = 6'h08;
      2'h2: down_group = 6'h02;
      default: down_group = 6'h01;
    endcase
  endfunction

  // ==========================================
  // Parameter registers
  logic [3:0] pd_r, pd_nxt, res_r, res_nxt, offt_r, offt_nxt;
  logic [9:0] lsw_r, lsw_nxt;
  logic [7:0] lss_r, lss_nxt;
  logic orig_r, orig_nxt, intp_r, intp_nxt, dbl_r, dbl_nxt;
  logic [1:0] blank_r, blank_nxt, down_r, down_nxt;
  sac_pkg::sac_chop_t mode_r, mode_nxt;
  logic fdc_r, fdc_nxt, floor_r, floor_nxt;
  logic [3:0] hend_r, hend_nxt, fdt_r, fdt_nxt, hst_r, hst_nxt, so_r, so_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic wr, ok, known, rv_r, rv_nxt, re_r, re_nxt;
  logic [31:0] wd, rd;
  always_comb begin
    wr = cmd_valid_i & cmd_wr_i;
    wd = cmd_wdata_i;
    ok = 1'b1;
    known = 1'b1;
    rd = 32'h0000_0000;
    case (cmd_num_i)
      `SAC_P_PD_RAMP: begin ok = wd[31:4] == 28'h0; rd = {28'h0, pd_r}; end
      `SAC_P_LS_WIDTH: begin ok = wd[31:10] == 22'h0; rd = {22'h0, lsw_r}; end
      `SAC_P_LS_STALL: begin ok = wd[31:8] == 24'h0; rd = {24'h0, lss_r}; end
      `SAC_P_REL_ORIGIN: begin ok = wd[31:1] == 31'h0; rd = {31'h0, orig_r}; end
      `SAC_P_USTEP_RES: begin ok = wd <= {28'h0, `SAC_RES_MAX}; rd = {28'h0, res_r}; end
      `SAC_P_INTERP: begin ok = wd[31:1] == 31'h0; rd = {31'h0, intp_r}; end
      `SAC_P_DBL_STEP: begin ok = wd[31:1] == 31'h0; rd = {31'h0, dbl_r}; end
      `SAC_P_BLANK: begin ok = wd[31:2] == 30'h0; rd = {30'h0, blank_r}; end
      `SAC_P_CHOP_MODE: begin ok = wd[31:1] == 31'h0; rd = {31'h0, mode_r}; end
      `SAC_P_FD_CMP_OFF: begin ok = wd[31:1] == 31'h0; rd = {31'h0, fdc_r}; end
      `SAC_P_HEND_FD: begin
        ok = wd[31:4] == 28'h0;
        rd = {28'h0, (mode_r == sac_pkg::SAC_CHOP_CONST) ? fdt_r : hend_r};
      end
      `SAC_P_HSTART_SO: begin
        ok = wd <= {28'h0, `SAC_HSTART_MAX};
        rd = {28'h0, (mode_r == sac_pkg::SAC_CHOP_CONST) ? so_r : hst_r};
      end
      `SAC_P_OFF_TIME: begin ok = wd[31:4] == 28'h0; rd = {28'h0, offt_r}; end
      `SAC_P_CUR_FLOOR: begin ok = wd[31:1] == 31'h0; rd = {31'h0, floor_r}; end
      `SAC_P_CUR_DOWN: begin ok = wd[31:2] == 30'h0; rd = {30'h0, down_r}; end
      default: begin ok = 1'b0; known = 1'b0; end
    endcase
    if (!cmd_wr_i) ok = known;
    {pd_nxt, lsw_nxt, lss_nxt, orig_nxt} = {pd_r, lsw_r, lss_r, orig_r};
    {res_nxt, intp_nxt, dbl_nxt, blank_nxt} = {res_r, intp_r, dbl_r, blank_r};
    mode_nxt = mode_r;
    {fdc_nxt, hend_nxt, fdt_nxt} = {fdc_r, hend_r, fdt_r};
    {hst_nxt, so_nxt, offt_nxt} = {hst_r, so_r, offt_r};
    {floor_nxt, down_nxt} = {floor_r, down_r};
    if (wr && ok) begin
      case (cmd_num_i)
        `SAC_P_PD_RAMP: pd_nxt = wd[3:0];
        `SAC_P_LS_WIDTH: lsw_nxt = wd[9:0];
        `SAC_P_LS_STALL: lss_nxt = wd[7:0];
        `SAC_P_REL_ORIGIN: orig_nxt = wd[0];
        `SAC_P_USTEP_RES: res_nxt = wd[3:0];
        `SAC_P_INTERP: intp_nxt = wd[0];
        `SAC_P_DBL_STEP: dbl_nxt = wd[0];
        `SAC_P_BLANK: blank_nxt = wd[1:0];
        `SAC_P_CHOP_MODE: mode_nxt = sac_pkg::sac_chop_t'(wd[0]);
        `SAC_P_FD_CMP_OFF: fdc_nxt = wd[0];
        `SAC_P_HEND_FD: begin
          fdt_nxt = chop_const_off_o ? wd[3:0] : fdt_r;
          hend_nxt = chop_const_off_o ? hend_r : wd[3:0];
        end
        `SAC_P_HSTART_SO: begin
          so_nxt = chop_const_off_o ? wd[3:0] : so_r;
          hst_nxt = chop_const_off_o ? hst_r : wd[3:0];
        end
        `SAC_P_OFF_TIME: offt_nxt = wd[3:0];
        `SAC_P_CUR_FLOOR: floor_nxt = wd[0];
        `SAC_P_CUR_DOWN: down_nxt = wd[1:0];
        default: ;
      endcase
    end
    rv_nxt = cmd_valid_i;
    re_nxt = cmd_valid_i & ~ok;
    rd_nxt = (cmd_valid_i && !cmd_wr_i && ok) ? rd : 32'h0000_0000;
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      {pd_r, lsw_r, lss_r, orig_r} <= '0;
      res_r <= `SAC_RST_USTEP_RES;
      {intp_r, dbl_r, fdc_r, floor_r} <= '0;
      blank_r <= `SAC_RST_BLANK;
      mode_r <= sac_pkg::SAC_CHOP_HYST;
      {hend_r, fdt_r, hst_r, so_r, down_r} <= '0;
      offt_r <= `SAC_RST_OFF_TIME;
      {rv_r, re_r} <= 2'b00;
      rd_r <= 32'h0000_0000;
    end else begin
      {pd_r, lsw_r, lss_r, orig_r} <= {pd_nxt, lsw_nxt, lss_nxt, orig_nxt};
      {res_r, intp_r, dbl_r, blank_r} <= {res_nxt, intp_nxt, dbl_nxt, blank_nxt};
      mode_r <= mode_nxt;
      {fdc_r, hend_r, fdt_r} <= {fdc_nxt, hend_nxt, fdt_nxt};
      {hst_r, so_r, offt_r} <= {hst_nxt, so_nxt, offt_nxt};
      {floor_r, down_r} <= {floor_nxt, down_nxt};
      {rv_r, re_r, rd_r} <= {rv_nxt, re_nxt, rd_nxt};
    end
  end
  assign rsp_valid_o = rv_r;
  assign rsp_err_o = re_r;
  assign rsp_rdata_o = rd_r;

  // ==========================================
  // Chopper and load settings
  logic [8:0] off_raw;
  assign off_raw = `SAC_OFF_BASE + {offt_r, 5'h00};
  assign off_cycles_o = (off_raw < `SAC_OFF_MIN) ? `SAC_OFF_MIN : off_raw;
  assign freewheel_o = offt_r == 4'h0;
  assign blank_time_o = blank_r;
  assign chop_const_off_o = mode_r == sac_pkg::SAC_CHOP_CONST;
  assign fd_cmp_off_o = chop_const_off_o & fdc_r;
  assign hyst_end_o = hend_r;
  assign fast_decay_o = fdt_r;
  assign hyst_start_o = hst_r;
  assign sine_offset_o = so_r;
  assign load_step_width_o = lsw_r;
  assign load_step_stall_o = lss_r;
  assign load_step_active_o = speed_i > min_speed_i;
  assign cur_min_o = floor_r ? {2'b00, cs_max_i[4:2]} : {1'b0, cs_max_i[4:1]};
  assign ustep_log2_o = 4'h8 - res_log2(res_r);

  // ==========================================
  // Power-down ramp
  sac_pkg::sac_pd_st_t pd_st_r, pd_st_nxt;
  logic [31:0] tick_r, tick_nxt;
  logic [3:0] lvl_r, lvl_nxt;
  always_comb begin
    pd_st_nxt = pd_st_r;
    tick_nxt = tick_r;
    lvl_nxt = lvl_r;
    case (pd_st_r)
      sac_pkg::SAC_PD_IDLE: begin
        if (motor_stopped_i && settle_done_i) begin
          lvl_nxt = pd_r;
          tick_nxt = 32'h0000_0000;
          pd_st_nxt = (pd_r == 4'h0) ? sac_pkg::SAC_PD_DONE : sac_pkg::SAC_PD_RAMP;
        end
      end
      sac_pkg::SAC_PD_RAMP: begin
        if (!motor_stopped_i) begin
          pd_st_nxt = sac_pkg::SAC_PD_IDLE;
        end else if (tick_r == 32'(PD_UNIT_CYC - 1)) begin
          tick_nxt = 32'h0000_0000;
          lvl_nxt = lvl_r - 4'h1;
          if (lvl_r == 4'h1) pd_st_nxt = sac_pkg::SAC_PD_DONE;
        end else begin
          tick_nxt = tick_r + 32'h0000_0001;
        end
      end
      sac_pkg::SAC_PD_DONE: begin
        lvl_nxt = 4'h0;
        if (!motor_stopped_i) pd_st_nxt = sac_pkg::SAC_PD_IDLE;
      end
      default: pd_st_nxt = sac_pkg::SAC_PD_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pd_st_r <= sac_pkg::SAC_PD_IDLE;
      tick_r <= 32'h0000_0000;
      lvl_r <= 4'h0;
    end else begin
      pd_st_r <= pd_st_nxt;
      tick_r <= tick_nxt;
      lvl_r <= lvl_nxt;
    end
  end
  assign pd_ramp_active_o = pd_st_r == sac_pkg::SAC_PD_RAMP;
  assign pd_level_o = (pd_st_r == sac_pkg::SAC_PD_IDLE) ? 4'hf : lvl_r;

  // ==========================================
  // Relative move origin
  logic rdv_r, rdv_nxt;
  logic [31:0] dest_r, dest_nxt;
  always_comb begin
    rdv_nxt = relative_move_command_i;
    dest_nxt = relative_move_command_i ?
      (orig_r ? actual_pos_i : target_pos_i) + rel_dist_i : dest_r;
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdv_r <= 1'b0;
      dest_r <= 32'h0000_0000;
    end else begin
      rdv_r <= rdv_nxt;
      dest_r <= dest_nxt;
    end
  end
  assign rel_dest_valid_o = rdv_r;
  assign rel_dest_o = dest_r;

  // ==========================================
  // Step input
  logic stp_m_r, stp_s_r, stp_p_r, dir_m_r, dir_s_r;
  logic [4:0] pend_r, pend_nxt;
  logic up_r, up_nxt, udir_r, udir_nxt;
  logic [8:0] amt_r, amt_nxt;
  logic trig, intp_act;
  always_comb begin
    intp_act = intp_r && res_r == `SAC_INTERP_RES;
    trig = dbl_r ? (stp_s_r ^ stp_p_r) : (stp_s_r & ~stp_p_r);
    pend_nxt = pend_r;
    up_nxt = 1'b0;
    amt_nxt = amt_r;
    udir_nxt = udir_r;
    if (pend_r != 5'h00) begin
      pend_nxt = pend_r - 5'h01;
      up_nxt = 1'b1;
      amt_nxt = 9'h001;
    end
    if (trig) begin
      udir_nxt = dir_s_r;
      if (intp_act) begin
        pend_nxt = (pend_nxt > 5'h0f) ? 5'h1f : pend_nxt + 5'h10;
      end else begin
        up_nxt = 1'b1;
        amt_nxt = 9'h100 >> res_log2(res_r);
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      {stp_m_r, stp_s_r, stp_p_r, dir_m_r, dir_s_r} <= 5'b00000;
      pend_r <= 5'h00;
      {up_r, udir_r} <= 2'b00;
      amt_r <= 9'h000;
    end else begin
      stp_m_r <= step_pin_i;
      stp_s_r <= stp_m_r;
      stp_p_r <= stp_s_r;
      dir_m_r <= dir_pin_i;
      dir_s_r <= dir_m_r;
      pend_r <= pend_nxt;
      {up_r, udir_r} <= {up_nxt, udir_nxt};
      amt_r <= amt_nxt;
    end
  end
  assign ustep_pulse_o = up_r;
  assign ustep_dir_o = udir_r;
  assign ustep_amount_o = amt_r;

  // ==========================================
  // Adaptive current decrement
  logic [5:0] hcnt_r, hcnt_nxt;
  logic dec_r, dec_nxt;
  always_comb begin
    hcnt_nxt = hcnt_r;
    dec_nxt = 1'b0;
    if (load_high_i) begin
      dec_nxt = hcnt_r + 6'h01 >= down_group(down_r);
      hcnt_nxt = dec_nxt ? 6'h00 : hcnt_r + 6'h01;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      hcnt_r <= 6'h00;
      dec_r <= 1'b0;
    end else begin
      hcnt_r <= hcnt_nxt;
      dec_r <= dec_nxt;
    end
  end
  assign cur_dec_o = dec_r;

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  freewheel_zero_a: assert property (wr && ok && cmd_num_i == `SAC_P_OFF_TIME
    && wd == 32'h0000_0000 |=> freewheel_o) else $error("freewheel not set");
  off_floor_a: assert property (!freewheel_o |-> off_cycles_o >= 9'h040)
    else $error("off time below 64");
  off_formula_a: assert property (offt_r > 4'h1 |->
    off_cycles_o == 9'h00c + 9'(offt_r) * 9'h020) else $error("off time formula");
  res_refuse_a: assert property (wr && cmd_num_i == `SAC_P_USTEP_RES
    && wd > 32'h0000_0008 |=> rsp_err_o && $stable(res_r)) else $error("bad code taken");
  interp_burst_a: assert property (trig && intp_act && pend_r == 5'h00
    |=> ##1 (ustep_pulse_o && ustep_amount_o == 9'h001) [*8]) else $error("burst short");
  dbl_fall_a: assert property (dbl_r && !intp_act && $fell(stp_s_r)
    |=> ustep_pulse_o) else $error("falling edge ignored");
  single_fall_a: assert property (!dbl_r && pend_r == 5'h00
    && $fell(stp_s_r) |=> !ustep_pulse_o) else $error("extra microstep");
  floor_a: assert property (floor_r |-> cur_min_o == cs_max_i >> 2)
    else $error("floor wrong");
  rel_dest_a: assert property (relative_move_command_i |=> rel_dest_valid_o
    && rel_dest_o == (($past(orig_r) ? $past(actual_pos_i) : $past(target_pos_i))
    + $past(rel_dist_i))) else $error("relative destination");
  pd_instant_a: assert property (pd_st_r == sac_pkg::SAC_PD_IDLE && pd_r == 4'h0
    && motor_stopped_i && settle_done_i |=> pd_level_o == 4'h0) else $error("pd slow");
  dec_fast_a: assert property (down_r == 2'h3 && load_high_i |=> cur_dec_o)
    else $error("no decrement");
  readback_a: assert property (cmd_valid_i && !cmd_wr_i
    && cmd_num_i == `SAC_P_OFF_TIME |=> rsp_rdata_o == {28'h0, $past(offt_r)})
    else $error("readback");
  cv_interp_c: cover property (trig && intp_act);
  cv_dbl_c: cover property (dbl_r && $fell(stp_s_r));
  cv_pd_c: cover property (pd_st_r == sac_pkg::SAC_PD_RAMP ##1
    pd_st_r == sac_pkg::SAC_PD_DONE);
  cv_dec_c: cover property (cur_dec_o && down_r == 2'h0);
endmodule
`default_nettype wire

// >>> sac_host_model.sv
`default_nettype none
module sac_host_model (
  // Clock
  input wire logic clk_i,
  // Command side
  output logic cmd_valid_o,
  output logic cmd_wr_o,
  output logic [7:0] cmd_num_o,
  output logic [31:0] cmd_wdata_o,
  // Answer side
  input wire logic rsp_valid_i,
  input wire logic rsp_err_i,
  input wire logic [31:0] rsp_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Host behaviour
  // Off-time setting the host prefers: 268 clocks, about 5.4 us at 50 MHz.
  localparam logic [3:0] OFF_REC = 4'h8;

  initial begin
    cmd_valid_o = 1'h0;
    cmd_wr_o = 1'h0;
    cmd_num_o = 8'h00;
    cmd_wdata_o = 32'h0000_0000;
  end

  // One set or get; a missing answer returns an unknown error flag.
  task automatic xfer(input logic wr, input logic [7:0] num, input logic [31:0] d,
                      output logic err, output logic [31:0] q);
    @(posedge clk_i);
    cmd_valid_o <= 1'h1;
    cmd_wr_o <= wr;
    cmd_num_o <= num;
    cmd_wdata_o <= d;
    @(posedge clk_i);
    cmd_valid_o <= 1'h0;
    cmd_num_o <= ~num;
    cmd_wdata_o <= ~d;
    #1;
    err = (rsp_valid_i === 1'h1) ? rsp_err_i : 1'hx;
    q = rsp_rdata_i;
  endtask
endmodule
`default_nettype wire

// >>> sac_axis_cfg_tb.sv
`default_nettype none
module sac_axis_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] num;
    logic [31:0] wd;
    logic werr;
    logic [31:0] rd;
    logic rerr;
  } sac_row_t;
  logic clk_i, nrst_i, cmd_valid_i, cmd_wr_i, rsp_valid_o, rsp_err_o;
  logic [7:0] cmd_num_i;
  logic [31:0] cmd_wdata_i, rsp_rdata_o, rel_dist_i, target_pos_i, actual_pos_i, rel_dest_o;
  logic motor_stopped_i, settle_done_i, pd_ramp_active_o, load_step_active_o;
  logic [3:0] pd_level_o, ustep_log2_o, hyst_end_o, fast_decay_o, hyst_start_o, sine_offset_o;
  logic [22:0] speed_i, min_speed_i;
  logic [9:0] load_step_width_o;
  logic [7:0] load_step_stall_o;
  logic relative_move_command_i, rel_dest_valid_o, step_pin_i, dir_pin_i;
  logic ustep_pulse_o, ustep_dir_o, chop_const_off_o, fd_cmp_off_o, freewheel_o;
  logic [8:0] ustep_amount_o, off_cycles_o;
  logic [1:0] blank_time_o;
  logic [4:0] cs_max_i, cur_min_o;
  logic load_high_i, cur_dec_o, e;
  logic [31:0] q;
  int n_fail, checked, n_us, sum_us, n_dec, n_act;
  sac_row_t rows [0:19];
  logic [3:0] offt [0:3];
  logic [8:0] ncyc [0:3];
  int ngrp [0:3];

  sac_axis_cfg #(.PD_UNIT_CYC(4)) dut (
    .clk_i, .nrst_i, .cmd_valid_i, .cmd_wr_i, .cmd_num_i, .cmd_wdata_i,
    .rsp_valid_o, .rsp_err_o, .rsp_rdata_o, .motor_stopped_i, .settle_done_i,
    .pd_ramp_active_o, .pd_level_o, .speed_i, .min_speed_i, .load_step_active_o,
    .load_step_width_o, .load_step_stall_o, .relative_move_command_i, .rel_dist_i,
    .target_pos_i, .actual_pos_i, .rel_dest_valid_o, .rel_dest_o, .step_pin_i,
    .dir_pin_i, .ustep_pulse_o, .ustep_dir_o, .ustep_amount_o, .ustep_log2_o,
    .blank_time_o, .chop_const_off_o, .fd_cmp_off_o, .hyst_end_o, .fast_decay_o,
    .hyst_start_o, .sine_offset_o, .off_cycles_o, .freewheel_o, .cs_max_i,
    .load_high_i, .cur_min_o, .cur_dec_o
  );

  sac_host_model host (
    .clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_wr_o(cmd_wr_i),
    .cmd_num_o(cmd_num_i), .cmd_wdata_o(cmd_wdata_i), .rsp_valid_i(rsp_valid_o),
    .rsp_err_i(rsp_err_o), .rsp_rdata_i(rsp_rdata_o)
  );

  // ==========================================
  // Checking helpers
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] num, input logic [31:0] d);
    host.xfer(1'h1, num, d, e, q);
    chk(e, 1'h0);
  endtask

  task automatic rd(input logic [7:0] num, input logic [31:0] exp);
    host.xfer(1'h0, num, 32'h0, e, q);
    chk({e, q}, {1'h0, exp});
  endtask

  task automatic steps();
    n_us = 0;
    sum_us = 0;
    @(posedge clk_i) step_pin_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    step_pin_i <= 1'h0;
    repeat (30) @(posedge clk_i);
    #1;
  endtask

  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge clk_i) load_high_i <= 1'h1;
      @(posedge clk_i) load_high_i <= 1'h0;
    end
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic relm(input logic org, input logic [31:0] exp);
    wr(8'h7f, org);
    @(posedge clk_i) relative_move_command_i <= 1'h1;
    @(posedge clk_i) relative_move_command_i <= 1'h0;
    #1;
    chk(rel_dest_valid_o, 1'h1);
    chk(rel_dest_o, exp);
  endtask

  // ==========================================
  // Clock, watchdog and event counters
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    print_verdict();
  end

  always @(posedge clk_i) begin
    if (ustep_pulse_o === 1'h1) begin
      n_us <= n_us + 1;
      sum_us <= sum_us + ustep_amount_o;
    end
    if (cur_dec_o === 1'h1) n_dec <= n_dec + 1;
    if (pd_ramp_active_o === 1'h1) n_act <= n_act + 1;
  end

  // ==========================================
  // Main sequence
  initial begin
    rows = '{
      '{8'h1f, 32'hf, 1'h0, 32'hf, 1'h0}, '{8'h20, 32'h3ff, 1'h0, 32'h3ff, 1'h0},
      '{8'h20, 32'h400, 1'h1, 32'h3ff, 1'h0}, '{8'h21, 32'hff, 1'h0, 32'hff, 1'h0},
      '{8'h7f, 32'h1, 1'h0, 32'h1, 1'h0}, '{8'h7f, 32'h2, 1'h1, 32'h1, 1'h0},
      '{8'h8c, 32'h9, 1'h1, 32'h8, 1'h0}, '{8'h8c, 32'h4, 1'h0, 32'h4, 1'h0},
      '{8'ha0, 32'h1, 1'h0, 32'h1, 1'h0}, '{8'ha1, 32'h1, 1'h0, 32'h1, 1'h0},
      '{8'ha2, 32'h3, 1'h0, 32'h3, 1'h0}, '{8'ha3, 32'h0, 1'h0, 32'h0, 1'h0},
      '{8'ha4, 32'h1, 1'h0, 32'h1, 1'h0}, '{8'ha5, 32'hf, 1'h0, 32'hf, 1'h0},
      '{8'ha6, 32'h8, 1'h0, 32'h8, 1'h0}, '{8'ha6, 32'h9, 1'h1, 32'h8, 1'h0},
      '{8'ha7, 32'hf, 1'h0, 32'hf, 1'h0}, '{8'ha8, 32'h1, 1'h0, 32'h1, 1'h0},
      '{8'ha9, 32'h3, 1'h0, 32'h3, 1'h0}, '{8'h22, 32'h5, 1'h1, 32'h0, 1'h1}};
    offt = '{4'h0, 4'h1, 4'h2, 4'hf};
    ncyc = '{9'h040, 9'h040, 9'h04c, 9'h1ec};
    ngrp = '{32, 8, 2, 1};
    {n_fail, checked, n_us, sum_us, n_dec, n_act} = '0;
    {nrst_i, motor_stopped_i, settle_done_i, relative_move_command_i} = 4'h0;
    {step_pin_i, dir_pin_i, load_high_i} = 3'h0;
    speed_i = 23'h0;
    min_speed_i = 23'h0;
    rel_dist_i = 32'h7;
    target_pos_i = 32'h64;
    actual_pos_i = 32'h32;
    cs_max_i = 5'h14;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'h1;
    @(posedge clk_i);
    #1;
    chk(off_cycles_o, 9'h06c);
    chk(freewheel_o, 1'h0);
    chk(pd_level_o, 4'hf);
    chk(load_step_active_o, 1'h0);
    rd(8'h8c, 32'h8);
    rd(8'ha2, 32'h2);
    rd(8'ha7, 32'h3);
    foreach (rows[i]) begin
      host.xfer(1'h1, rows[i].num, rows[i].wd, e, q);
      chk(e, rows[i].werr);
      host.xfer(1'h0, rows[i].num, 32'h0, e, q);
      chk({e, q}, {rows[i].rerr, rows[i].rd});
    end
    chk(load_step_width_o, 10'h3ff);
    chk(load_step_stall_o, 8'hff);
    chk(blank_time_o, 2'h3);
    chk(hyst_end_o, 4'hf);
    chk(ustep_log2_o, 4'h4);
    chk(cur_min_o, 5'h05);
    wr(8'ha8, 32'h0);
    chk(cur_min_o, 5'h0a);
    wr(8'ha5, 32'h3);
    wr(8'ha3, 32'h1);
    chk(chop_const_off_o, 1'h1);
    chk(fd_cmp_off_o, 1'h1);
    wr(8'ha5, 32'h9);
    wr(8'ha6, 32'h5);
    chk(fast_decay_o, 4'h9);
    chk(sine_offset_o, 4'h5);
    wr(8'ha3, 32'h0);
    chk(chop_const_off_o, 1'h0);
    chk(fd_cmp_off_o, 1'h0);
    chk(hyst_start_o, 4'h8);
    rd(8'ha5, 32'h3);
    wr(8'ha3, 32'h1);
    rd(8'ha5, 32'h9);
    for (int i = 0; i < 4; i++) begin
      wr(8'ha7, offt[i]);
      chk(off_cycles_o, ncyc[i]);
      chk(freewheel_o, offt[i] == 4'h0);
    end
    wr(8'ha7, host.OFF_REC);
    chk(off_cycles_o, 9'h10c);
    wr(8'ha0, 32'h0);
    wr(8'ha1, 32'h0);
    @(posedge clk_i) dir_pin_i <= 1'h1;
    for (int c = 0; c < 9; c++) begin
      wr(8'h8c, c);
      steps();
      chk(n_us, 1);
      chk(sum_us, 256 >> c);
    end
    chk(ustep_dir_o, 1'h1);
    wr(8'h8c, 32'h4);
    wr(8'ha1, 32'h1);
    steps();
    chk(n_us, 2);
    chk(sum_us, 32);
    wr(8'ha1, 32'h0);
    wr(8'ha0, 32'h1);
    steps();
    chk(n_us, 16);
    chk(sum_us, 16);
    wr(8'h8c, 32'h5);
    steps();
    chk(sum_us, 8);
    relm(1'h0, 32'h6b);
    relm(1'h1, 32'h39);
    @(posedge clk_i) speed_i <= 23'h1;
    #1;
    chk(load_step_active_o, 1'h1);
    @(posedge clk_i) min_speed_i <= 23'h1;
    #1;
    chk(load_step_active_o, 1'h0);
    for (int c = 0; c < 4; c++) begin
      wr(8'ha9, c);
      n_dec = 0;
      pulses(ngrp[c] - 1);
      chk(n_dec, 0);
      pulses(1);
      chk(n_dec, 1);
    end
    wr(8'h1f, 32'h2);
    n_act = 0;
    @(posedge clk_i) {motor_stopped_i, settle_done_i} <= 2'h3;
    repeat (20) @(posedge clk_i);
    #1;
    chk(pd_level_o, 4'h0);
    chk(n_act, 8);
    @(posedge clk_i) motor_stopped_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    #1;
    chk(pd_level_o, 4'hf);
    wr(8'h1f, 32'h0);
    n_act = 0;
    @(posedge clk_i) motor_stopped_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    #1;
    chk(pd_level_o, 4'h0);
    chk(n_act, 0);
    @(posedge clk_i) nrst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'h1;
    @(posedge clk_i);
    #1;
    chk(pd_level_o, 4'h0);
    chk(off_cycles_o, 9'h06c);
    rd(8'ha5, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
